// ===== design/acc_pkg.sv
// Package with register map, field layout, reset values and timing for calibration control.
package acc_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [9:0] IDX_RUN_ENABLE = 10'h061;
  localparam logic [9:0] IDX_CONFIG     = 10'h062;
  localparam logic [9:0] IDX_STATUS     = 10'h06A;
  localparam logic [9:0] IDX_PIN_CONFIG = 10'h06B;
  localparam logic [9:0] IDX_SOFT_TRIG  = 10'h06C;
  localparam logic [9:0] IDX_LOW_POWER  = 10'h06E;

  // Field positions in the calibration configuration register.
  localparam int CFG_FG_RUN_BIT    = 0;
  localparam int CFG_BG_EN_BIT     = 1;
  localparam int CFG_FG_OS_BIT     = 2;
  localparam int CFG_BG_OS_BIT     = 3;
  localparam int CFG_OS_FILT_BIT   = 4;
  // Field positions in status, pin configuration, trigger, low-power and run enable registers.
  localparam int STAT_FOREGROUND_COMPLETE_FLAG_BIT  = 0;
  localparam int STAT_HALTED_BIT   = 1;
  localparam int PIN_TRIG_SEL_BIT  = 0;
  localparam int PIN_STAT_SEL_LSB  = 1;
  localparam int SOFT_TRIG_BIT     = 0;
  localparam int LP_EN_BIT         = 0;
  localparam int SLEEP_UNTIL_TRIGGER_BIT       = 1;
  localparam int RUN_EN_BIT        = 0;

  // Reset values.
  localparam logic [7:0] RST_RUN_ENABLE = 8'h01;
  localparam logic [7:0] RST_CONFIG     = 8'h01;
  localparam logic [7:0] RST_PIN_CONFIG = 8'h00;
  localparam logic [7:0] RST_SOFT_TRIG  = 8'h01;
  localparam logic [7:0] RST_LOW_POWER  = 8'h88;

  // Status pin select codes.
  localparam logic [1:0] STAT_SEL_FOREGROUND_COMPLETE_FLAG = 2'h0;
  localparam logic [1:0] STAT_SEL_ALARM   = 2'h2;

  // Timing: clock period and the modelled calibration step durations.
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int FG_TIME_NS      = 2000;
  localparam int BG_PHASE_NS     = 500;
  localparam int FG_CYCLES       = (FG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BG_PHASE_CYCLES = (BG_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Calibration configuration fields.
  typedef struct packed {
    logic [2:0] spare;
    logic       offset_filter_enable;
    logic       background_offset_cal_enable;
    logic       foreground_offset_cal_enable;
    logic       background_cal_enable;
    logic       foreground_cal_run;
  } acc_cfg_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ACC_HOLD,
    ACC_CLEAR,
    ACC_FG,
    ACC_BG,
    ACC_HALT,
    ACC_IDLE
  } acc_state_t;

endpackage

// ===== design/acc_trig.sv
// Calibration trigger source: pin synchroniser and software/pin multiplexer.
`timescale 1ns/10ps
module acc_trig (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pce,
  input  wire logic trigger_input_pin,
  input  wire logic software_trigger_bit,
  input  wire logic trigger_source_select,
  output logic      cal_trigger
);

  logic pin_meta;
  logic pin_sync;

  // pin synchroniser
  // Two flops; only the second stage is looked at by the mux.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else if (pce) begin
      pin_meta <= trigger_input_pin;
      pin_sync <= pin_meta;
    end
  end

  // trigger source mux
  // The unselected source is ignored entirely; the result is registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_trigger <= 1'b1;
    end else if (pce) begin
      cal_trigger <= trigger_source_select ? pin_sync : software_trigger_bit;
    end
  end

endmodule

// ===== design/acc_ctrl.sv
// Calibration control and status block with an APB register slave.
// Summary of operation
// - Config bit 4 high enables offset filtering during calibration.
// - Bit 3 enables background offset calibration, only with background enabled.
// - Bit 2 enables foreground offset calibration, only with foreground run set.
// - Bit 1 enables background calibration; cleared by default.
// - Start resets calibration values, then runs foreground if bit 0 set.
// - Halted status bit 1 sets when background stops, clears on resume.
// - With background off, halted sets after foreground completes or is skipped.
// - Foreground-complete status bit 0 sets when foreground finishes; read only.
// - Status pin select: 0 done flag, 2 alarm, 3 low, 1 reserved.
// - Source select 0 uses software bit, 1 uses the synchronised pin.
// - Software trigger bit behaves as the pin; resets to 1.
// - Run enable set runs calibration; cleared holds calibration in reset.
// - Sleep-until-trigger mode wakes the core when the trigger goes low.
`timescale 1ns/10ps
module acc_ctrl #(
  parameter int FG_CYCLES       = acc_pkg::FG_CYCLES,
  parameter int BG_PHASE_CYCLES = acc_pkg::BG_PHASE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trigger_input_pin,
  input  wire logic        alarm_flag,
  output logic             status_output_pin,
  output logic             core_wake,
  output logic             cal_values_reset,
  output logic             fg_cal_active,
  output logic             bg_cal_active,
  output logic             fg_offset_active,
  output logic             bg_offset_active,
  output logic             offset_filter_active
);

  localparam int CW = 16;

  // Counts must fit the phase counter and never be zero.
  if (FG_CYCLES < 1 || FG_CYCLES >= (1 << CW)) begin : g_chk_fg
    $error("FG_CYCLES out of range");
  end
  if (BG_PHASE_CYCLES < 1 || BG_PHASE_CYCLES >= (1 << CW)) begin : g_chk_bg
    $error("BG_PHASE_CYCLES out of range");
  end

  localparam logic [CW-1:0] FG_LAST = CW'(FG_CYCLES - 1);
  localparam logic [CW-1:0] BG_LAST = CW'(BG_PHASE_CYCLES - 1);

  acc_pkg::acc_cfg_t   cfg;
  acc_pkg::acc_state_t state;
  acc_pkg::acc_state_t next_state;
  logic [7:0]          pin_config;
  logic [7:0]          soft_trig;
  logic [7:0]          low_power;
  logic                run_enable;
  logic                foreground_complete_flag;
  logic                bg_halted;
  logic [CW-1:0]       count;
  logic                cal_trigger;
  logic                access;
  logic                wr_take;
  logic [9:0]          index;
  logic                count_end;

  // True when the index selects an implemented register.
  function automatic logic is_mapped(input logic [9:0] idx);
    return idx == acc_pkg::IDX_RUN_ENABLE || idx == acc_pkg::IDX_CONFIG ||
           idx == acc_pkg::IDX_STATUS     || idx == acc_pkg::IDX_PIN_CONFIG ||
           idx == acc_pkg::IDX_SOFT_TRIG  || idx == acc_pkg::IDX_LOW_POWER;
  endfunction

  // Read value of the register at an index; unmapped indices read zero, and run enable and status pad unused bits with zero.
  function automatic logic [7:0] read_value(input logic [9:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      acc_pkg::IDX_RUN_ENABLE: v[acc_pkg::RUN_EN_BIT] = run_enable;
      acc_pkg::IDX_CONFIG:     v = cfg;
      acc_pkg::IDX_STATUS: begin
        v[acc_pkg::STAT_FOREGROUND_COMPLETE_FLAG_BIT] = foreground_complete_flag;
        v[acc_pkg::STAT_HALTED_BIT]  = bg_halted;
      end
      acc_pkg::IDX_PIN_CONFIG: v = pin_config;
      acc_pkg::IDX_SOFT_TRIG:  v = soft_trig;
      acc_pkg::IDX_LOW_POWER:  v = low_power;
      default:                 v = 8'h00;
    endcase
    return v;
  endfunction

  assign index     = paddr[11:2];
  assign access    = psel && penable;
  assign wr_take   = access && pready && pwrite && is_mapped(index) && paddr[1:0] == 2'h0;
  assign count_end = (state == acc_pkg::ACC_FG && count == FG_LAST) ||
                     (state == acc_pkg::ACC_BG && count == BG_LAST);

  // Trigger source selection lives in its own module.
  acc_trig u_trig (
    .pclk                  (pclk),
    .presetn               (presetn),
    .pce                   (pce),
    .trigger_input_pin     (trigger_input_pin),
    .software_trigger_bit  (soft_trig[acc_pkg::SOFT_TRIG_BIT]),
    .trigger_source_select (pin_config[acc_pkg::PIN_TRIG_SEL_BIT]),
    .cal_trigger           (cal_trigger)
  );

  // APB answer: pready rises one cycle into the access phase, so every
  // transfer takes setup plus two access cycles; data and error are set with it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (pce) begin
      if (access && !pready) begin
        pready  <= 1'b1;
        pslverr <= !is_mapped(index) || paddr[1:0] != 2'h0;
        prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, read_value(index)};
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Writable registers; writes land only at the edge that completes the access.
  // The status register is read only and ignores writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_enable <= acc_pkg::RST_RUN_ENABLE[acc_pkg::RUN_EN_BIT];
      cfg        <= acc_pkg::RST_CONFIG;
      pin_config <= acc_pkg::RST_PIN_CONFIG;
      soft_trig  <= acc_pkg::RST_SOFT_TRIG;
      low_power  <= acc_pkg::RST_LOW_POWER;
    end else if (pce && wr_take) begin
      unique case (index)
        acc_pkg::IDX_RUN_ENABLE: run_enable <= pwdata[acc_pkg::RUN_EN_BIT];
        // Configuration is taken at any time; the host keeps it still while running.
        acc_pkg::IDX_CONFIG:     cfg        <= pwdata[7:0];
        acc_pkg::IDX_PIN_CONFIG: pin_config <= pwdata[7:0];
        acc_pkg::IDX_SOFT_TRIG:  soft_trig  <= pwdata[7:0];
        acc_pkg::IDX_LOW_POWER:  low_power  <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Sequencer next state.
  always_comb begin
    next_state = state;
    unique case (state)
      acc_pkg::ACC_HOLD: begin
        if (run_enable) next_state = acc_pkg::ACC_CLEAR;
      end
      acc_pkg::ACC_CLEAR: begin
        if (cfg.foreground_cal_run) next_state = acc_pkg::ACC_FG;
        else if (cfg.background_cal_enable) next_state = acc_pkg::ACC_BG;
        else next_state = acc_pkg::ACC_IDLE;
      end
      acc_pkg::ACC_FG: begin
        if (count_end) begin
          next_state = cfg.background_cal_enable ? acc_pkg::ACC_BG : acc_pkg::ACC_IDLE;
        end
      end
      // halt at phase end
      // A low trigger is a stop request, honoured only at a phase boundary.
      acc_pkg::ACC_BG: begin
        if (count_end && !cal_trigger) next_state = acc_pkg::ACC_HALT;
      end
      acc_pkg::ACC_HALT: begin
        if (cal_trigger) next_state = acc_pkg::ACC_BG;
      end
      acc_pkg::ACC_IDLE: begin
        next_state = acc_pkg::ACC_IDLE;
      end
      default: next_state = acc_pkg::ACC_HOLD;
    endcase
    if (!run_enable) next_state = acc_pkg::ACC_HOLD;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= acc_pkg::ACC_HOLD;
    end else if (pce) begin
      state <= next_state;
    end
  end

  // Step counter: restarts on every state change and at each phase end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (pce) begin
      if (next_state != state || count_end) count <= '0;
      else count <= count + CW'(1);
    end
  end

  // foreground complete flag
  // Cleared when a new run starts so a stale flag never survives a restart.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      foreground_complete_flag <= 1'b0;
    end else if (pce) begin
      if (state == acc_pkg::ACC_FG && count_end) foreground_complete_flag <= 1'b1;
      else if (state == acc_pkg::ACC_CLEAR) foreground_complete_flag <= 1'b0;
    end
  end

  // halted on background stop or without background
  // Halted flag: set on a background stop or on a finished or skipped foreground
  // with background disabled; cleared when background resumes or a run restarts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bg_halted <= 1'b0;
    end else if (pce) begin
      if (next_state == acc_pkg::ACC_HALT || next_state == acc_pkg::ACC_IDLE) begin
        bg_halted <= 1'b1;
      end else if (next_state == acc_pkg::ACC_BG || next_state == acc_pkg::ACC_CLEAR) begin
        bg_halted <= 1'b0;
      end
    end
  end

  // Engine controls, all registered so the outputs are glitch free.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_values_reset     <= 1'b1;
      fg_cal_active        <= 1'b0;
      bg_cal_active        <= 1'b0;
      fg_offset_active     <= 1'b0;
      bg_offset_active     <= 1'b0;
      offset_filter_active <= 1'b0;
    end else if (pce) begin
      cal_values_reset     <= next_state == acc_pkg::ACC_HOLD ||
                              next_state == acc_pkg::ACC_CLEAR;
      fg_cal_active        <= next_state == acc_pkg::ACC_FG;
      fg_offset_active     <= next_state == acc_pkg::ACC_FG &&
                              cfg.foreground_offset_cal_enable;
      bg_cal_active        <= next_state == acc_pkg::ACC_BG;
      bg_offset_active     <= next_state == acc_pkg::ACC_BG &&
                              cfg.background_offset_cal_enable;
      offset_filter_active <= (next_state == acc_pkg::ACC_FG ||
                               next_state == acc_pkg::ACC_BG) && cfg.offset_filter_enable;
    end
  end

  // status pin routing
  // The reserved code drives the pin low, the same as code 3.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_output_pin <= 1'b0;
    end else if (pce) begin
      unique case (pin_config[acc_pkg::PIN_STAT_SEL_LSB +: 2])
        acc_pkg::STAT_SEL_FOREGROUND_COMPLETE_FLAG: status_output_pin <= foreground_complete_flag;
        acc_pkg::STAT_SEL_ALARM:   status_output_pin <= alarm_flag;
        default:                   status_output_pin <= 1'b0;
      endcase
    end
  end

  // wake on low trigger
  // Only meaningful with low-power enabled and trigger-controlled sleep chosen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_wake <= 1'b0;
    end else if (pce) begin
      core_wake <= low_power[acc_pkg::LP_EN_BIT] && low_power[acc_pkg::SLEEP_UNTIL_TRIGGER_BIT] &&
                   !cal_trigger;
    end
  end

  // Checks on the sequencer and status behaviour.
  // start clears then runs
  a_start_clears_first: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && state == acc_pkg::ACC_HOLD && run_enable) |=> state == acc_pkg::ACC_CLEAR)
    else $error("run start did not pass through clear");

  a_fg_after_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && state == acc_pkg::ACC_CLEAR && run_enable && cfg.foreground_cal_run)
    |=> state == acc_pkg::ACC_FG)
    else $error("foreground did not start after clear");

  a_foreground_complete_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && state == acc_pkg::ACC_FG && count_end) |=> foreground_complete_flag)
    else $error("foreground complete flag not set");

  a_halt_no_bg: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && run_enable && state == acc_pkg::ACC_FG && count_end && !cfg.background_cal_enable)
    |=> bg_halted && state == acc_pkg::ACC_IDLE)
    else $error("halted flag missing after foreground without background");

  a_resume_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && state == acc_pkg::ACC_HALT && next_state == acc_pkg::ACC_BG)
    |=> !bg_halted && bg_cal_active)
    else $error("halted flag stayed set after resume");

  a_hold_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && !run_enable) |=> state == acc_pkg::ACC_HOLD && !fg_cal_active && !bg_cal_active)
    else $error("calibration ran while run enable cleared");

  a_fg_offset_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fg_offset_active |-> fg_cal_active && cfg.foreground_cal_run)
    else $error("foreground offset active without foreground");

  a_bg_offset_gate: assert property (@(posedge pclk) disable iff (!presetn)
    bg_offset_active |-> bg_cal_active && cfg.background_cal_enable)
    else $error("background offset active without background");

  a_pin_low_code: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && pin_config[2:1] == 2'h3) |=> !status_output_pin)
    else $error("status pin not low for code three");

  a_wake_on_low: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && low_power[1:0] == 2'h3 && !cal_trigger) |=> core_wake)
    else $error("core not woken by low trigger");

  a_halt_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && run_enable && state == acc_pkg::ACC_BG && count_end && !cal_trigger)
    |=> bg_halted && state == acc_pkg::ACC_HALT)
    else $error("halted flag missing after background stop");

  a_pin_shows_done: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && pin_config[acc_pkg::PIN_STAT_SEL_LSB +: 2] == acc_pkg::STAT_SEL_FOREGROUND_COMPLETE_FLAG)
    |=> status_output_pin == $past(foreground_complete_flag))
    else $error("status pin does not follow foreground complete flag");

endmodule

// ===== verif/acc_host.sv
// Host-side model that drives the calibration trigger pin.
`timescale 1ns/10ps
module acc_host #(
  parameter int LAG = 3
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trig_level,
  output logic      trigger_input_pin
);
  logic [7:0] pipe;

  // Pin rests high.
  // The pin idles high so that no stop is asked for until the host lowers it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe <= 8'hFF;
    end else begin
      pipe <= {pipe[6:0], trig_level};
    end
  end

  // A longer lag models a slow host; the pin follows the request after LAG edges.
  assign trigger_input_pin = pipe[LAG-1];
endmodule

// ===== verif/test_acc_ctrl.sv
// Self-checking bench for the calibration control block.
`timescale 1ns/10ps
module test_acc_ctrl;
  logic        pclk;
  logic        presetn;
  logic        pce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig_level;
  logic        trigger_input_pin;
  logic        alarm_flag;
  logic        status_output_pin;
  logic        core_wake;
  logic        cal_values_reset;
  logic        fg_cal_active;
  logic        bg_cal_active;
  logic        fg_offset_active;
  logic        bg_offset_active;
  logic        offset_filter_active;
  logic [31:0] rd;
  logic        err;
  int          failures;
  int          checks_done;
  int          cycles = 0;
  int          n;

  // Short engine counts keep the run brief.
  acc_ctrl #(.FG_CYCLES(4), .BG_PHASE_CYCLES(3)) i_acc_ctrl (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_input_pin(trigger_input_pin),
    .alarm_flag(alarm_flag), .status_output_pin(status_output_pin),
    .core_wake(core_wake), .cal_values_reset(cal_values_reset),
    .fg_cal_active(fg_cal_active), .bg_cal_active(bg_cal_active),
    .fg_offset_active(fg_offset_active), .bg_offset_active(bg_offset_active),
    .offset_filter_active(offset_filter_active)
  );

  acc_host #(.LAG(3)) i_acc_host (
    .pclk(pclk), .presetn(presetn), .trig_level(trig_level),
    .trigger_input_pin(trigger_input_pin)
  );

  // Clock generator, 25 ns period.
  always #12.5 pclk = ~pclk;

  // Hang guard: a run past the ceiling counts as a mismatch.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; an edge passes first so strobes never toggle twice at once.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    k = 0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      check("pready", 32'h0, 32'h1);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(name, rd, {24'h000000, exp});
  endtask

  // Status is polled because engine phases end on their own schedule.
  task automatic poll_status(input logic [7:0] exp);
    int k;
    for (k = 0; k < 40; k++) begin
      apb(1'b0, acc_pkg::IDX_STATUS, 8'h00);
      if (rd[7:0] === exp) break;
    end
    check("status", rd, {24'h000000, exp});
  endtask

  // Main sequence.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    trig_level = 1'b1;
    alarm_flag = 1'b1;
    pce = 1'b1;
    failures = 0;
    checks_done = 0;
    repeat (2) @(posedge pclk);
    check("reset_hold", {31'h0, cal_values_reset}, 32'h1);
    presetn <= 1'b1;
    rd_chk("run_enable", acc_pkg::IDX_RUN_ENABLE, 8'h01);
    rd_chk("config", acc_pkg::IDX_CONFIG, 8'h01);
    rd_chk("pin_config", acc_pkg::IDX_PIN_CONFIG, 8'h00);
    rd_chk("soft_trig", acc_pkg::IDX_SOFT_TRIG, 8'h01);
    rd_chk("low_power", acc_pkg::IDX_LOW_POWER, 8'h88);
    poll_status(8'h03);
    // Every pin code, alarm low then high.
    for (n = 0; n < 8; n++) begin
      alarm_flag <= n[2];
      apb(1'b1, acc_pkg::IDX_PIN_CONFIG, {5'h00, n[1:0], 1'b0});
      repeat (3) @(posedge pclk);
      check("status_pin", {31'h0, status_output_pin},
            {31'h0, (n[1:0] == 2'h0) | (n[1:0] == 2'h2 && n[2])});
    end
    apb(1'b1, acc_pkg::IDX_STATUS, 8'h00);
    check("status_wr_err", {31'h0, err}, 32'h0);
    rd_chk("status_ro", acc_pkg::IDX_STATUS, 8'h03);
    apb(1'b0, 10'h063, 8'h00);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, acc_pkg::IDX_RUN_ENABLE, 8'h00);
    repeat (2) @(posedge pclk);
    check("held", {30'h0, cal_values_reset, fg_cal_active}, 32'h2);
    apb(1'b1, acc_pkg::IDX_CONFIG, 8'h1F);
    apb(1'b1, acc_pkg::IDX_RUN_ENABLE, 8'h01);
    for (n = 0; n < 40 && fg_cal_active !== 1'b1; n++) @(posedge pclk);
    check("fg_run", {28'h0, fg_cal_active, fg_offset_active, offset_filter_active, bg_cal_active},
          32'hE);
    // Clock enable low must freeze the foreground run well past its normal length.
    pce <= 1'b0;
    repeat (10) @(posedge pclk);
    check("fg_frozen", {31'h0, fg_cal_active}, 32'h1);
    pce <= 1'b1;
    for (n = 0; n < 40 && bg_cal_active !== 1'b1; n++) @(posedge pclk);
    check("bg_run", {28'h0, bg_cal_active, bg_offset_active, offset_filter_active, fg_cal_active},
          32'hE);
    poll_status(8'h01);
    apb(1'b1, acc_pkg::IDX_LOW_POWER, 8'h8B);
    apb(1'b1, acc_pkg::IDX_SOFT_TRIG, 8'h00);
    poll_status(8'h03);
    check("wake_low", {31'h0, core_wake}, 32'h1);
    apb(1'b1, acc_pkg::IDX_SOFT_TRIG, 8'h01);
    poll_status(8'h01);
    check("wake_high", {31'h0, core_wake}, 32'h0);
    trig_level <= 1'b0;
    repeat (20) @(posedge pclk);
    rd_chk("pin_ignored", acc_pkg::IDX_STATUS, 8'h01);
    apb(1'b1, acc_pkg::IDX_PIN_CONFIG, 8'h01);
    poll_status(8'h03);
    trig_level <= 1'b1;
    poll_status(8'h01);
    apb(1'b1, acc_pkg::IDX_SOFT_TRIG, 8'h00);
    repeat (20) @(posedge pclk);
    rd_chk("soft_ignored", acc_pkg::IDX_STATUS, 8'h01);
    // Host returns to the no-trigger setting.
    apb(1'b1, acc_pkg::IDX_SOFT_TRIG, 8'h01);
    apb(1'b1, acc_pkg::IDX_PIN_CONFIG, 8'h00);
    apb(1'b1, acc_pkg::IDX_RUN_ENABLE, 8'h00);
    apb(1'b1, acc_pkg::IDX_CONFIG, 8'h0C);
    apb(1'b1, acc_pkg::IDX_RUN_ENABLE, 8'h01);
    poll_status(8'h02);
    check("skip", {28'h0, fg_offset_active, bg_offset_active, fg_cal_active, bg_cal_active},
          32'h0);
    finish_test();
  end
endmodule
